// ---- shared/lpm_pkg.sv ----
package lpm_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] REG_POWER_CONTROL = 8'h00;
	localparam logic [7:0] REG_IRQ_ENABLE    = 8'h04;
	localparam logic [7:0] REG_IRQ_CONFIG    = 8'h08;
	localparam logic [7:0] REG_STATUS        = 8'h0c;

	// power_control_reg fields
	localparam int PC_IDLE_BIT = 0;
	localparam int PC_PD_BIT   = 1;
	localparam int PC_UF0_BIT  = 2;
	localparam int PC_UF1_BIT  = 3;
	localparam int PC_WIDTH    = 4;

	// interrupt enable fields
	localparam int IE_EXT0_BIT  = 0;
	localparam int IE_EXT1_BIT  = 1;
	localparam int IE_OTHER_LSB = 2;
	localparam int IE_GLOBAL_BIT = 7;
	localparam int IE_WIDTH     = 8;

	// interrupt configuration fields
	localparam int CFG_EDGE0_BIT = 0;
	localparam int CFG_EDGE1_BIT = 1;
	localparam int CFG_PRIO0_BIT = 2;
	localparam int CFG_PRIO1_BIT = 3;
	localparam int CFG_WIDTH     = 4;

	// status fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_EMU_BIT  = 2;
	localparam int STAT_PEND_LSB = 3;
	localparam int STAT_OSC_BIT  = 5;
	localparam int STAT_CPU_BIT  = 6;

	// values after reset
	localparam logic [PC_WIDTH-1:0]  POWER_CONTROL_RESET = 4'h0;
	localparam logic [IE_WIDTH-1:0]  IRQ_ENABLE_RESET    = 8'h00;
	localparam logic [CFG_WIDTH-1:0] IRQ_CONFIG_RESET    = 4'h0;
	localparam logic                 PIN_IDLE_LEVEL      = 1'b1;

	// reset pin must stay high this many oscillator periods
	localparam int RESET_MIN_PERIODS   = 24;
	localparam int OSC_PERIODS_PER_CLK = 1;
	localparam int RESET_MIN_CYCLES    = (RESET_MIN_PERIODS + OSC_PERIODS_PER_CLK - 1) / OSC_PERIODS_PER_CLK;
	localparam int RESET_CNT_W         = 5;

	// wake source codes
	localparam logic [2:0] SRC_EXT0      = 3'h0;
	localparam logic [2:0] SRC_EXT1      = 3'h1;
	localparam logic [2:0] SRC_OTHER_LSB = 3'h2;

	typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PD, ST_PD_WAKE} lpm_state_e;

endpackage

// ---- shared/wake_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// synchronised view of one external interrupt pin
interface wake_if;
	logic low;
	logic fall;
	modport chan (output low, output fall);
	modport ctrl (input low, input fall);
endinterface

`default_nettype wire

// ---- src/ext_wake_channel.sv ----
`timescale 1ns/1ps
`default_nettype none

module ext_wake_channel
	import lpm_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin_n,
	wake_if.chan      wk
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} chan_s;

	chan_s r_reg;
	chan_s r_next;

	// meta is read only by sync, so no logic sees a metastable value
	always_comb begin
		r_next      = r_reg;
		r_next.meta = pin_n;
		r_next.sync = r_reg.meta;
		r_next.prev = r_reg.sync;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '{PIN_IDLE_LEVEL, PIN_IDLE_LEVEL, PIN_IDLE_LEVEL};
		end else begin
			r_reg <= r_next;
		end
	end

	assign wk.low  = ~r_reg.sync;
	assign wk.fall = r_reg.prev & ~r_reg.sync;

endmodule

`default_nettype wire

// ---- src/low_power_mode_control.sv ----
// Function
// - the write setting the idle bit is the last step before idle begins
// - idle stops the cpu clock, peripherals and interrupt logic keep running
// - all cpu state is kept unchanged throughout idle
// - ports hold their levels in idle, both strobes driven high
// - enabled interrupt in idle clears idle bit, wakes, resumes after entry point
// - reset pin held twenty-four oscillator periods completes a reset from idle
// - both user flags are freely writable, also with the idle-entering write
// - power-down stops the oscillator after the entering write
// - ram and registers keep contents throughout power-down
// - power-down ends on hardware reset or one of two external pins
// - external wake needs that pin enabled, level or edge configured
// - pin low restarts the oscillator, pin release completes the exit
// - both enabled: first low restarts, first release exits, higher priority served
// - after servicing the wake, execution continues after the entering write
// - reset exit reinitialises registers, interrupt exit leaves them, ram kept
// - idle and power-down both set follows power-down exit, clears both bits
// - strobe low with fetch high during reset, held through release, enters emulation
// - emulation weakly pulls strobes and ports 1-3, floats port 0, oscillator on
// - an ordinary reset leaves emulation mode
// - power-down bit is bit 1, set by software, cleared by any reset
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_control
	import lpm_pkg::*;
#(
	parameter int NUM_OTHER = 3
) (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic [31:0]               prdata,
	// device pins
	input  wire logic                 reset_pin,
	input  wire logic                 ext_irq_zero_n,
	input  wire logic                 ext_irq_one_n,
	input  wire logic                 ale_i,
	output logic                      ale_o,
	output logic                      ale_oe,
	output logic                      ale_pullup,
	input  wire logic                 program_fetch_strobe_i,
	output logic                      program_fetch_strobe_o,
	output logic                      program_fetch_strobe_oe,
	output logic                      program_fetch_strobe_pullup,
	output logic                      port0_float,
	output logic                      port123_pullup,
	output logic                      port_hold,
	// core side
	input  wire logic                 ale_core,
	input  wire logic                 fetch_core,
	input  wire logic [NUM_OTHER-1:0] other_irq,
	input  wire logic [1:0]           ext_irq_ack,
	output logic                      cpu_clk_en,
	output logic                      periph_clk_en,
	output logic                      osc_enable,
	output logic                      core_reset,
	output logic                      emulation_mode,
	output logic                      wake_pulse,
	output logic [2:0]                wake_src
);

	// the other sources share the enable byte below the global bit
	if (NUM_OTHER < 1 || NUM_OTHER > IE_GLOBAL_BIT - IE_OTHER_LSB) begin
		$error("NUM_OTHER must lie between 1 and 5");
	end

	typedef struct packed {
		lpm_state_e              state;
		logic [PC_WIDTH-1:0]     power_control_reg;
		logic [IE_WIDTH-1:0]     ie;
		logic [CFG_WIDTH-1:0]    cfg;
		logic [1:0]              pend;
		logic [1:0]              seen_low;
		logic [2:0]              pin_meta;
		logic [2:0]              pin_sync;
		logic [RESET_CNT_W-1:0]  rst_cnt;
		logic                    core_rst;
		logic                    emu_arm;
		logic                    emu;
		logic                    wake;
		logic [2:0]              src;
		logic [31:0]             rdata;
		logic                    ale_q;
		logic                    fetch_q;
		logic                    cpu_en;
		logic                    per_en;
		logic                    osc_en;
	} ctrl_s;

	ctrl_s r_reg;
	ctrl_s r_next;

	// release of the asynchronous reset, kept outside the state struct
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// external interrupt pin channels
	wake_if     wk [2] ();
	logic [1:0] ext_low;
	logic [1:0] ext_fall;

	ext_wake_channel u_ext0 (
		.clk   (clk),
		.rst_n (rst_n),
		.pin_n (ext_irq_zero_n),
		.wk    (wk[0])
	);

	ext_wake_channel u_ext1 (
		.clk   (clk),
		.rst_n (rst_n),
		.pin_n (ext_irq_one_n),
		.wk    (wk[1])
	);

	assign ext_low  = {wk[1].low, wk[0].low};
	assign ext_fall = {wk[1].fall, wk[0].fall};

	// decode helpers
	logic                 setup_ph;
	logic                 access_ph;
	logic                 addr_ok;
	logic [1:0]           ext_en;
	logic [1:0]           ext_act;
	logic [1:0]           edge_mode;
	logic [NUM_OTHER-1:0] other_act;
	logic                 glob;
	logic                 rst_pin;
	logic                 ale_pin;
	logic                 fetch_pin;

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign addr_ok   = (paddr == REG_POWER_CONTROL) || (paddr == REG_IRQ_ENABLE) ||
	                   (paddr == REG_IRQ_CONFIG) || (paddr == REG_STATUS);
	assign glob      = r_reg.ie[IE_GLOBAL_BIT];
	assign ext_en    = {r_reg.ie[IE_EXT1_BIT], r_reg.ie[IE_EXT0_BIT]};
	assign edge_mode = {r_reg.cfg[CFG_EDGE1_BIT], r_reg.cfg[CFG_EDGE0_BIT]};
	assign rst_pin   = r_reg.pin_sync[0];
	assign ale_pin   = r_reg.pin_sync[1];
	assign fetch_pin = r_reg.pin_sync[2];

	// edge-configured pins use the latched flag, level pins the pin itself
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ext_act[i] = edge_mode[i] ? r_reg.pend[i] : ext_low[i];
		end
		other_act = other_irq & r_reg.ie[IE_OTHER_LSB +: NUM_OTHER];
	end

	// picks the external source to serve; ext1 wins only at a higher priority
	function automatic logic [2:0] pick_ext(input logic [1:0] req, input logic [CFG_WIDTH-1:0] cfg);
		logic ext1_first;
		ext1_first = cfg[CFG_PRIO1_BIT] & ~cfg[CFG_PRIO0_BIT];
		if (req[1] && (!req[0] || ext1_first)) begin
			pick_ext = SRC_EXT1;
		end else begin
			pick_ext = SRC_EXT0;
		end
	endfunction

	// picks the lowest numbered other source
	function automatic logic [2:0] pick_other(input logic [NUM_OTHER-1:0] req);
		logic [2:0] idx;
		idx = SRC_OTHER_LSB;
		for (int i = NUM_OTHER - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = SRC_OTHER_LSB + 3'(i);
			end
		end
		pick_other = idx;
	endfunction

	// whole controller next-state
	always_comb begin
		logic [1:0] wake_ext;
		logic [1:0] released;
		r_next = r_reg;
		wake_ext = 2'h0;
		released = 2'h0;
		r_next.wake = 1'b0;

		// pins from outside the clock domain: meta feeds only sync
		r_next.pin_meta = {program_fetch_strobe_i, ale_i, reset_pin};
		r_next.pin_sync = r_reg.pin_meta;

		// edge flags: a new falling edge wins over an acknowledge in the same cycle
		for (int i = 0; i < 2; i++) begin
			if (ext_fall[i]) begin
				r_next.pend[i] = 1'b1;
			end else if (ext_irq_ack[i]) begin
				r_next.pend[i] = 1'b0;
			end
		end

		// apb register writes take effect at the access edge
		if (access_ph && pwrite) begin
			if (paddr == REG_POWER_CONTROL) begin
				r_next.power_control_reg = pwdata[PC_WIDTH-1:0];
			end else if (paddr == REG_IRQ_ENABLE) begin
				r_next.ie = pwdata[IE_WIDTH-1:0];
			end else if (paddr == REG_IRQ_CONFIG) begin
				r_next.cfg = pwdata[CFG_WIDTH-1:0];
			end
		end

		// read data is captured in setup so it comes from a flip-flop
		if (setup_ph && !pwrite) begin
			if (paddr == REG_POWER_CONTROL) begin
				r_next.rdata = 32'(r_reg.power_control_reg);
			end else if (paddr == REG_IRQ_ENABLE) begin
				r_next.rdata = 32'(r_reg.ie);
			end else if (paddr == REG_IRQ_CONFIG) begin
				r_next.rdata = 32'(r_reg.cfg);
			end else if (paddr == REG_STATUS) begin
				r_next.rdata = 32'h0;
				r_next.rdata[STAT_MODE_LSB +: 2] = 2'(r_reg.state);
				r_next.rdata[STAT_EMU_BIT] = r_reg.emu;
				r_next.rdata[STAT_PEND_LSB +: 2] = r_reg.pend;
				r_next.rdata[STAT_OSC_BIT] = r_reg.osc_en;
				r_next.rdata[STAT_CPU_BIT] = r_reg.cpu_en;
			end else begin
				r_next.rdata = 32'h0;
			end
		end

		// mode sequencing
		case (r_reg.state)
			ST_RUN: begin
				// entry one cycle after the write, so the writing access is the last one
				if (r_reg.power_control_reg[PC_PD_BIT]) begin
					r_next.state = ST_PD;
				end else if (r_reg.power_control_reg[PC_IDLE_BIT]) begin
					r_next.state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				// any enabled source wakes; global enable gates them all
				if (glob && ((|(ext_act & ext_en)) || (|other_act))) begin
					r_next.state = ST_RUN;
					r_next.power_control_reg[PC_IDLE_BIT] = 1'b0;
					r_next.wake = 1'b1;
					if (|(ext_act & ext_en)) begin
						r_next.src = pick_ext(ext_act & ext_en, r_reg.cfg);
					end else begin
						r_next.src = pick_other(other_act);
					end
					if (r_next.src == SRC_EXT0 && edge_mode[0]) begin
						r_next.pend[0] = ext_fall[0];
					end
					if (r_next.src == SRC_EXT1 && edge_mode[1]) begin
						r_next.pend[1] = ext_fall[1];
					end
				end
			end
			ST_PD: begin
				// of the interrupt sources, only the two external pins can restart the oscillator
				wake_ext = ext_low & ext_en & {2{glob}};
				if (|wake_ext) begin
					r_next.state = ST_PD_WAKE;
					r_next.seen_low = wake_ext;
				end
			end
			ST_PD_WAKE: begin
				wake_ext = ext_low & ext_en & {2{glob}};
				released = r_reg.seen_low & ~ext_low;
				r_next.seen_low = r_reg.seen_low | wake_ext;
				if (|released) begin
					// first release completes the exit; higher priority of those seen low
					r_next.state = ST_RUN;
					r_next.src = pick_ext(r_reg.seen_low, r_reg.cfg);
					r_next.wake = 1'b1;
					r_next.power_control_reg[PC_IDLE_BIT] = 1'b0;
					r_next.power_control_reg[PC_PD_BIT] = 1'b0;
					r_next.seen_low = 2'h0;
					r_next.pend = 2'h0;
				end
			end
			default: begin
				r_next.state = ST_RUN;
			end
		endcase

		// reset pin qualification; since the oscillator runs, a short count suffices
		if (rst_pin) begin
			if (r_reg.rst_cnt != RESET_CNT_W'(RESET_MIN_CYCLES)) begin
				r_next.rst_cnt = r_reg.rst_cnt + 1'b1;
			end
		end else begin
			r_next.rst_cnt = '0;
		end
		r_next.core_rst = rst_pin && (r_next.rst_cnt == RESET_CNT_W'(RESET_MIN_CYCLES));

		// emulation arming: strobe low with fetch high, kept low through the release
		if (rst_pin || r_reg.core_rst) begin
			r_next.emu_arm = ~ale_pin & fetch_pin & (r_reg.emu_arm | rst_pin);
			if (ale_pin) begin
				r_next.emu_arm = 1'b0;
			end
		end
		if (r_reg.core_rst && !r_next.core_rst) begin
			r_next.emu = r_reg.emu_arm & ~ale_pin;
		end

		// a qualified reset reinitialises every register; ram lives outside and is untouched
		if (r_reg.core_rst) begin
			r_next.state = ST_RUN;
			r_next.power_control_reg = POWER_CONTROL_RESET;
			r_next.ie = IRQ_ENABLE_RESET;
			r_next.cfg = IRQ_CONFIG_RESET;
			r_next.pend = 2'h0;
			r_next.seen_low = 2'h0;
			r_next.wake = 1'b0;
		end

		// clock controls follow the next state so they change with it
		r_next.cpu_en = (r_next.state == ST_RUN);
		r_next.per_en = (r_next.state == ST_RUN) || (r_next.state == ST_IDLE);
		r_next.osc_en = (r_next.state != ST_PD) || r_next.emu;

		// strobes forced high whenever the cpu clock is stopped
		r_next.ale_q = r_next.cpu_en ? ale_core : 1'b1;
		r_next.fetch_q = r_next.cpu_en ? fetch_core : 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg          <= '0;
			r_reg.state    <= ST_RUN;
			r_reg.power_control_reg     <= POWER_CONTROL_RESET;
			r_reg.ie       <= IRQ_ENABLE_RESET;
			r_reg.cfg      <= IRQ_CONFIG_RESET;
			r_reg.cpu_en   <= 1'b1;
			r_reg.per_en   <= 1'b1;
			r_reg.osc_en   <= 1'b1;
			r_reg.ale_q    <= 1'b1;
			r_reg.fetch_q  <= 1'b1;
			r_reg.pin_meta <= 3'h6;
			r_reg.pin_sync <= 3'h6;
		end else begin
			r_reg <= r_next;
		end
	end

	// apb answers with no wait states; unmapped addresses give an error
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~addr_ok;
	assign prdata  = r_reg.rdata;

	// pin drivers; in emulation both strobes and ports 1-3 are released to weak pull-ups, port 0 floats
	assign ale_o                       = r_reg.ale_q;
	assign ale_oe                      = ~r_reg.emu;
	assign ale_pullup                  = r_reg.emu;
	assign program_fetch_strobe_o      = r_reg.fetch_q;
	assign program_fetch_strobe_oe     = ~r_reg.emu;
	assign program_fetch_strobe_pullup = r_reg.emu;
	assign port0_float                 = r_reg.emu;
	assign port123_pullup              = r_reg.emu;
	assign port_hold                   = ~r_reg.cpu_en;

	assign cpu_clk_en     = r_reg.cpu_en;
	assign periph_clk_en  = r_reg.per_en;
	assign osc_enable     = r_reg.osc_en;
	assign core_reset     = r_reg.core_rst;
	assign emulation_mode = r_reg.emu;
	assign wake_pulse     = r_reg.wake;
	assign wake_src       = r_reg.src;

endmodule

`default_nettype wire

// ---- verif/lpm_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpm_sva
	import lpm_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        reset_pin,
	input wire logic        ext_irq_zero_n,
	input wire logic        ext_irq_one_n,
	input wire logic        ale_o,
	input wire logic        ale_oe,
	input wire logic        ale_pullup,
	input wire logic        program_fetch_strobe_o,
	input wire logic        program_fetch_strobe_oe,
	input wire logic        program_fetch_strobe_pullup,
	input wire logic        port0_float,
	input wire logic        port123_pullup,
	input wire logic        port_hold,
	input wire logic        cpu_clk_en,
	input wire logic        periph_clk_en,
	input wire logic        osc_enable,
	input wire logic        core_reset,
	input wire logic        emulation_mode,
	input wire logic        wake_pulse
);
	logic [5:0] pin_cnt;
	logic [2:0] up_cnt;
	logic [3:0] low_hist;
	logic [1:0] mode_hist;
	logic       mode_wr;

	// a mode write is any power control write with a mode bit set
	assign mode_wr = psel & penable & pwrite & (paddr == REG_POWER_CONTROL) & (|pwdata[1:0]);

	// short histories; counters saturate so long pin holds never wrap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_cnt <= 6'h00;
			up_cnt <= 3'h0;
			low_hist <= 4'h0;
			mode_hist <= 2'h0;
		end else begin
			pin_cnt <= !reset_pin ? 6'h00 : (pin_cnt == 6'h3f ? pin_cnt : pin_cnt + 6'h01);
			up_cnt <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
			low_hist <= {low_hist[2:0], ~(ext_irq_zero_n & ext_irq_one_n)};
			mode_hist <= {mode_hist[0], mode_wr};
		end
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_emu_held;
		emulation_mode [*2];
	endsequence

	a_emu_pins: assert property (s_emu_held |-> ale_pullup && program_fetch_strobe_pullup && port0_float
		&& port123_pullup && osc_enable && !ale_oe && !program_fetch_strobe_oe) else $error("emulation pin state wrong");
	a_hold_strobes: assert property (port_hold && !emulation_mode |-> ale_o && ale_oe
		&& program_fetch_strobe_o && program_fetch_strobe_oe) else $error("strobes not high while ports held");
	a_idle_periph: assert property ($fell(cpu_clk_en) && osc_enable |-> periph_clk_en && port_hold)
		else $error("idle entry stopped peripherals or released ports");
	a_idle_cause: assert property ($fell(cpu_clk_en) |-> mode_hist != 2'h0) else $error("cpu clock stopped unasked");
	a_pd_stop: assert property ($fell(osc_enable) |-> mode_hist != 2'h0 && !cpu_clk_en && !periph_clk_en)
		else $error("oscillator stopped wrongly");
	a_osc_cause: assert property ($rose(osc_enable) && !core_reset && !$past(core_reset) |-> |low_hist)
		else $error("oscillator restart without pin low");
	a_wake_run: assert property (wake_pulse |-> ##[0:1] (cpu_clk_en && osc_enable))
		else $error("wake left cpu stopped");
	a_reset_min: assert property ($rose(core_reset) && up_cnt == 3'h7 |-> $past(pin_cnt, 2) >= 6'h18)
		else $error("reset taken from short pin pulse");
	a_reset_done: assert property (pin_cnt == 6'h18 |-> ##2 core_reset) else $error("long reset pin not taken");
endmodule

bind low_power_mode_control lpm_sva chk_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .reset_pin(reset_pin), .ext_irq_zero_n(ext_irq_zero_n),
	.ext_irq_one_n(ext_irq_one_n), .ale_o(ale_o), .ale_oe(ale_oe), .ale_pullup(ale_pullup),
	.program_fetch_strobe_o(program_fetch_strobe_o), .program_fetch_strobe_oe(program_fetch_strobe_oe),
	.program_fetch_strobe_pullup(program_fetch_strobe_pullup), .port0_float(port0_float),
	.port123_pullup(port123_pullup), .port_hold(port_hold), .cpu_clk_en(cpu_clk_en),
	.periph_clk_en(periph_clk_en), .osc_enable(osc_enable), .core_reset(core_reset),
	.emulation_mode(emulation_mode), .wake_pulse(wake_pulse));
`default_nettype wire

// ---- verif/lpm_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpm_far_side (
	input  wire logic clk,
	input  wire logic ale_o,
	input  wire logic ale_oe,
	input  wire logic ale_pullup,
	input  wire logic program_fetch_strobe_o,
	input  wire logic program_fetch_strobe_oe,
	input  wire logic program_fetch_strobe_pullup,
	output logic      ext_irq_zero_n,
	output logic      ext_irq_one_n,
	output logic      reset_pin,
	output logic      ale_i,
	output logic      program_fetch_strobe_i
);
	logic ale_pull_low = 1'b0;
	logic tog = 1'b0;

	// a floating strobe without pull-up wanders, so show a changing level
	always @(posedge clk) tog <= ~tog;

	// pin levels from every party; the pod's strong pull-down wins
	assign ale_i = ale_pull_low ? 1'b0 : ale_oe ? ale_o : ale_pullup ? 1'b1 : tog;
	assign program_fetch_strobe_i = program_fetch_strobe_oe ? program_fetch_strobe_o : program_fetch_strobe_pullup ? 1'b1 : tog;

	initial begin
		ext_irq_zero_n = 1'b1;
		ext_irq_one_n = 1'b1;
		reset_pin = 1'b0;
	end

	// supply is taken as good; the caller holds each level long enough to restart
	task automatic drive_irq(input logic z, input logic o);
		@(posedge clk);
		ext_irq_zero_n <= z;
		ext_irq_one_n <= o;
	endtask

	// reset held n periods; with em the strobe stays low across the release
	task automatic reset_pulse(input int n, input logic em);
		@(posedge clk);
		reset_pin <= 1'b1;
		ale_pull_low <= em;
		repeat (n) @(posedge clk);
		reset_pin <= 1'b0;
		repeat (8) @(posedge clk);
		ale_pull_low <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- verif/low_power_mode_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control_test
	import lpm_pkg::*;
;
	logic        clk = 1'b0;
	logic        resetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        rpin, irq0_n, irq1_n, ale_i, ale_o, ale_oe, ale_pu, fs_i, fs_o, fs_oe, fs_pu;
	logic        p0_fl, p123_pu, hold, ale_core, fetch_core, cpu_en, per_en, osc_en, core_rst, emu, wake;
	logic [2:0]  other_irq, wsrc;
	logic [1:0]  ack;
	int          err_total, cmp_count;
	localparam logic [31:0] RUN_STAT = (32'h1 << STAT_OSC_BIT) | (32'h1 << STAT_CPU_BIT);

	always #5 clk = ~clk;

	low_power_mode_control #(.NUM_OTHER(3)) dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.reset_pin(rpin), .ext_irq_zero_n(irq0_n), .ext_irq_one_n(irq1_n), .ale_i(ale_i), .ale_o(ale_o),
		.ale_oe(ale_oe), .ale_pullup(ale_pu), .program_fetch_strobe_i(fs_i), .program_fetch_strobe_o(fs_o),
		.program_fetch_strobe_oe(fs_oe), .program_fetch_strobe_pullup(fs_pu), .port0_float(p0_fl),
		.port123_pullup(p123_pu), .port_hold(hold), .ale_core(ale_core), .fetch_core(fetch_core),
		.other_irq(other_irq), .ext_irq_ack(ack), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
		.osc_enable(osc_en), .core_reset(core_rst), .emulation_mode(emu), .wake_pulse(wake), .wake_src(wsrc));

	lpm_far_side far_u (.clk(clk), .ale_o(ale_o), .ale_oe(ale_oe), .ale_pullup(ale_pu),
		.program_fetch_strobe_o(fs_o), .program_fetch_strobe_oe(fs_oe), .program_fetch_strobe_pullup(fs_pu),
		.ext_irq_zero_n(irq0_n), .ext_irq_one_n(irq1_n), .reset_pin(rpin), .ale_i(ale_i),
		.program_fetch_strobe_i(fs_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; waits on pready for at most 20 cycles, then flags a missing answer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(n < 20, 1'b1, "apb answer");
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rdat, exp, "read data");
		chk(rerr, 1'b0, "read error");
	endtask

	task automatic pin_reset(input logic em);
		int n;
		n = 0;
		fork
			far_u.reset_pulse(24, em);
			while (core_rst !== 1'b1 && n < 60) begin
				@(posedge clk);
				n++;
			end
		join
		chk(n < 60, 1'b1, "core reset taken");
		chk(core_rst, 1'b0, "core reset released");
	endtask

	task automatic wait_wake(input logic [2:0] s);
		int n;
		n = 0;
		while (wake !== 1'b1 && n < 80) begin
			@(posedge clk);
			n++;
		end
		chk(wake, 1'b1, "wake pulse");
		chk(wsrc, s, "wake source");
		@(posedge clk);
		ack <= 2'b11;
		@(posedge clk);
		ack <= 2'b00;
	endtask

	task automatic tally_and_finish;
		$display("mismatches %0d comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, other_irq, ack} = '0;
		{ale_core, fetch_core} = 2'b11;
		err_total = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk(REG_POWER_CONTROL, 32'h0);
		rdchk(REG_IRQ_ENABLE, 32'h0);
		xfer(1'b1, REG_STATUS, 32'hff);
		rdchk(REG_STATUS, RUN_STAT);
		xfer(1'b0, 8'h10, 32'h0);
		chk(rdat, 32'h0, "unmapped read");
		chk(rerr, 1'b1, "unmapped error");
		xfer(1'b1, REG_POWER_CONTROL, 32'hc);
		rdchk(REG_POWER_CONTROL, 32'hc);
		// idle with strobes low from the core, woken by an enabled timer request
		xfer(1'b1, REG_IRQ_ENABLE, 32'h84);
		{ale_core, fetch_core} <= 2'b00;
		xfer(1'b1, REG_POWER_CONTROL, 32'h5);
		repeat (2) @(posedge clk);
		chk({cpu_en, per_en, osc_en, hold, ale_o, fs_o}, 6'h1f, "idle outputs");
		other_irq <= 3'b001;
		wait_wake(SRC_OTHER_LSB);
		{ale_core, fetch_core, other_irq} <= 5'h18;
		rdchk(REG_POWER_CONTROL, 32'h4);
		// masked request leaves idle alone, a 24 period pin reset ends it
		xfer(1'b1, REG_IRQ_ENABLE, 32'h80);
		xfer(1'b1, REG_POWER_CONTROL, 32'h1);
		other_irq <= 3'b010;
		repeat (10) @(posedge clk);
		chk(cpu_en, 1'b0, "masked request woke idle");
		pin_reset(1'b0);
		other_irq <= 3'b000;
		rdchk(REG_IRQ_ENABLE, 32'h0);
		// power-down without global enable stays asleep until reset
		xfer(1'b1, REG_IRQ_ENABLE, 32'h05);
		xfer(1'b1, REG_POWER_CONTROL, 32'h2);
		repeat (2) @(posedge clk);
		chk({cpu_en, per_en, osc_en}, 3'h0, "power-down outputs");
		far_u.drive_irq(1'b0, 1'b1);
		repeat (10) @(posedge clk);
		chk(osc_en, 1'b0, "woke without global enable");
		far_u.drive_irq(1'b1, 1'b1);
		pin_reset(1'b0);
		rdchk(REG_POWER_CONTROL, 32'h0);
		// pin wake in level then edge mode; registers survive
		for (int m = 0; m < 2; m++) begin
			xfer(1'b1, REG_IRQ_ENABLE, 32'h85);
			xfer(1'b1, REG_IRQ_CONFIG, m);
			xfer(1'b1, REG_POWER_CONTROL, 32'h2);
			other_irq <= 3'b001;
			repeat (6) @(posedge clk);
			chk(osc_en, 1'b0, "woken by non-pin request");
			other_irq <= 3'b000;
			far_u.drive_irq(1'b0, 1'b1);
			repeat (6) @(posedge clk);
			chk({osc_en, cpu_en}, 2'b10, "pin low restart");
			far_u.drive_irq(1'b1, 1'b1);
			wait_wake(SRC_EXT0);
			rdchk(REG_POWER_CONTROL, 32'h0);
			rdchk(REG_IRQ_ENABLE, 32'h85);
			rdchk(REG_IRQ_CONFIG, m);
		end
		// both bits, both pins low, ext1 has priority; first release exits
		xfer(1'b1, REG_IRQ_CONFIG, 32'h8);
		xfer(1'b1, REG_IRQ_ENABLE, 32'h83);
		xfer(1'b1, REG_POWER_CONTROL, 32'h3);
		far_u.drive_irq(1'b0, 1'b0);
		repeat (6) @(posedge clk);
		chk(osc_en, 1'b1, "restart with both low");
		far_u.drive_irq(1'b1, 1'b0);
		wait_wake(SRC_EXT1);
		far_u.drive_irq(1'b1, 1'b1);
		rdchk(REG_POWER_CONTROL, 32'h0);
		chk(cpu_en, 1'b1, "idle entered after combined exit");
		// emulation entry and exit by the pod
		pin_reset(1'b1);
		repeat (2) @(posedge clk);
		chk({emu, ale_pu, fs_pu, p0_fl, p123_pu, osc_en}, 6'h3f, "emulation pins");
		rdchk(REG_STATUS, RUN_STAT | (32'h1 << STAT_EMU_BIT));
		pin_reset(1'b0);
		chk(emu, 1'b0, "emulation kept after reset");
		tally_and_finish();
	end

	// watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
